//--- hdl/pport_pkg.sv
package pport_pkg;
  // ---------------------------------------------------------------
  // Action select coding
  // ---------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // ---------------------------------------------------------------
  // Command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] FUSE_LO_RST = 8'hff;
  localparam logic [7:0] FUSE_HI_RST = 8'hff;
  localparam logic [7:0] FUSE_EX_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam int LOCK_BASIC_ONE_BIT = 0;
  localparam int LOCK_BASIC_TWO_BIT = 1;
  localparam logic [7:0] LOCK_BASIC_MASK = 8'h03;
  localparam logic [7:0] LOCK_BOOT_MASK = 8'h3c;
  localparam logic [7:0] SIG_MAX_ADDR = 8'h02;
  localparam logic [7:0] CAL_ADDR = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int ENTRY_HOLD_US = 10;
  localparam int ENTRY_HOLD_CYC = ENTRY_HOLD_US * CLK_MHZ;
  localparam int PROG_BUSY_CYC = 64;
  localparam int STROBE_CYC = 2;
endpackage

//--- hdl/pport_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pport_if;
  logic action_select_hi;
  logic action_select_lo;
  logic low_byte_select;
  logic upper_byte_select;
  logic page_latch_strobe;
  logic load_strobe;
  logic write_n;
  logic out_en_n;
  logic done_flag;
  logic prog_mode;
  logic [7:0] data_prog;
  logic [7:0] data_prog_oe;
  logic [7:0] data_dev;
  logic [7:0] data_dev_oe;
  logic [7:0] data_bus;
  // Resolve the shared bus from the two enables; undriven bits float high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      data_bus[i] = data_dev_oe[i] ? data_dev[i] : (data_prog_oe[i] ? data_prog[i] : 1'b1);
    end
  end
  modport dev (
    input action_select_hi, action_select_lo, low_byte_select, upper_byte_select,
    input page_latch_strobe, load_strobe, write_n, out_en_n, prog_mode, data_bus,
    output done_flag, data_dev, data_dev_oe
  );
  modport prog (
    output action_select_hi, action_select_lo, low_byte_select, upper_byte_select,
    output page_latch_strobe, load_strobe, write_n, out_en_n, prog_mode,
    output data_prog, data_prog_oe,
    input done_flag, data_bus
  );
endinterface
`default_nettype wire

//--- hdl/pport_dev.sv
// How it works
// - Nop command load clears internal write state
// - Programmer loads EEPROM page then latches
// - Program strobe commits page, done drops low
// - Flash read drives low/high word byte
// - EEPROM read drives addressed byte
// - Fuse low write: zero programs, one erases
// - Fuse high uses low select one
// - Extended fuse uses upper select one
// - Lock write: zero programs lock bit
// - Lock mode three blocks boot lock writes
// - Lock bits unprogram only by chip erase or reset
// - Fuse/lock read chosen by two byte selects
// - Signature byte read at address zero to two
// - Calibration byte read with low select one
// - Chip erase fills flash and EEPROM ones
// - Load strobe decodes two action select bits
// - Entry code held zero ten microseconds
// - Data bus driven from a cycle after output enable falls until a cycle after it rises
`timescale 1ns/1ps
`default_nettype none
module pport_dev
  import pport_pkg::*;
#(
  parameter int FLASH_AW = 8,
  parameter int EE_AW = 6,
  parameter int PAGE_AW = 2,
  parameter logic [7:0] SIG0 = 8'h1e, // Arbitrary value
  parameter logic [7:0] SIG1 = 8'h55, // Arbitrary value
  parameter logic [7:0] SIG2 = 8'h0a, // Arbitrary value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Programming port
  pport_if.dev PP
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } state_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ERASE = 3'b001,
    OP_FLASH = 3'b010,
    OP_EE = 3'b011,
    OP_FUSE = 3'b100,
    OP_LOCK = 3'b101
  } op_t;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [15:0] flash_q [2**FLASH_AW];
  logic [7:0] ee_q [2**EE_AW];
  logic [15:0] fpage_q [2**PAGE_AW];
  logic [7:0] epage_q [2**PAGE_AW];
  logic [2**PAGE_AW-1:0] fvalid_q, evalid_q;
  logic [7:0] fuse_lo_q, fuse_hi_q, fuse_ex_q, lock_q;
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q, dat_lo_q, dat_hi_q;
  logic ls_prev_q, pl_prev_q, wr_prev_q;
  state_t state_q, state_d;
  op_t op_q, op_d;
  logic [7:0] opdata_q, opdata_d;
  logic [1:0] opsel_q, opsel_d;
  logic [$clog2(PROG_BUSY_CYC+1)-1:0] cnt_q, cnt_d;
  logic done_q;
  logic [7:0] dout_q, dout_oe_q;

  // Edge detect of programmer strobes; inputs are synchronous
  wire ls_rise = PP.load_strobe & ~ls_prev_q;
  wire pl_rise = PP.page_latch_strobe & ~pl_prev_q & (state_q == ST_IDLE); // Ignored while busy
  wire wr_fall = ~PP.write_n & wr_prev_q;
  wire [1:0] act = {PP.action_select_hi, PP.action_select_lo};
  wire [FLASH_AW-1:0] faddr = FLASH_AW'({addr_hi_q, addr_lo_q});
  wire [EE_AW-1:0] eaddr = EE_AW'({addr_hi_q, addr_lo_q});
  wire [PAGE_AW-1:0] pidx = addr_lo_q[PAGE_AW-1:0];
  wire lock_mode3 = ~lock_q[LOCK_BASIC_ONE_BIT] & ~lock_q[LOCK_BASIC_TWO_BIT];

  // ---------------------------------------------------------------
  // Program strobe decode: start of a self-timed operation
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    opdata_d = opdata_q;
    opsel_d = opsel_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (wr_fall && PP.prog_mode) begin
          opdata_d = dat_lo_q;
          opsel_d = {PP.upper_byte_select, PP.low_byte_select};
          cnt_d = ($clog2(PROG_BUSY_CYC+1))'(PROG_BUSY_CYC);
          state_d = ST_BUSY;
          case (cmd_q)
            CMD_ERASE: op_d = OP_ERASE;
            CMD_WR_FLASH: op_d = OP_FLASH;
            CMD_WR_EE: op_d = (PP.low_byte_select) ? OP_NONE : OP_EE;
            CMD_WR_FUSE: op_d = OP_FUSE;
            CMD_WR_LOCK: op_d = OP_LOCK;
            default: begin
              op_d = OP_NONE;
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_BUSY: begin
        if (cnt_q == '0) begin
          state_d = ST_IDLE;
          op_d = OP_NONE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      opdata_q <= 8'h00;
      opsel_q <= 2'h0;
      cnt_q <= '0;
      done_q <= 1'b1;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      opdata_q <= opdata_d;
      opsel_q <= opsel_d;
      cnt_q <= cnt_d;
      done_q <= (state_d == ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Load registers, page buffers and arrays
  // ---------------------------------------------------------------
  // Memory arrays use no reset so they infer as plain storage; commits
  // happen on the last busy cycle so done rises with the data in place.
  wire commit = (state_q == ST_BUSY) && (cnt_q == '0);
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ls_prev_q <= 1'b0;
      pl_prev_q <= 1'b0;
      wr_prev_q <= 1'b1;
      cmd_q <= CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      dat_lo_q <= 8'h00;
      dat_hi_q <= 8'h00;
      fvalid_q <= '0;
      evalid_q <= '0;
      fuse_lo_q <= FUSE_LO_RST;
      fuse_hi_q <= FUSE_HI_RST;
      fuse_ex_q <= FUSE_EX_RST;
      lock_q <= LOCK_RST;
    end else begin
      ls_prev_q <= PP.load_strobe;
      pl_prev_q <= PP.page_latch_strobe;
      wr_prev_q <= PP.write_n;
      if (ls_rise && PP.prog_mode && state_q == ST_IDLE) begin
        case (act)
          ACT_ADDR: begin
            if (PP.low_byte_select) addr_hi_q <= PP.data_bus;
            else addr_lo_q <= PP.data_bus;
          end
          ACT_DATA: begin
            if (PP.low_byte_select) dat_hi_q <= PP.data_bus;
            else dat_lo_q <= PP.data_bus;
          end
          ACT_CMD: begin
            cmd_q <= PP.data_bus;
            if (PP.data_bus == CMD_NOP) begin
              fvalid_q <= '0;
              evalid_q <= '0;
            end
          end
          default: ;
        endcase
      end
      if (pl_rise && PP.prog_mode) begin
        if (cmd_q == CMD_WR_EE) evalid_q[pidx] <= 1'b1;
        if (cmd_q == CMD_WR_FLASH) fvalid_q[pidx] <= 1'b1;
      end
      if (commit) begin
        case (op_q)
          OP_FLASH: fvalid_q <= '0;
          OP_EE: evalid_q <= '0;
          OP_FUSE: begin
            case (opsel_q)
              2'b01: fuse_hi_q <= opdata_q;
              2'b10: fuse_ex_q <= opdata_q;
              default: fuse_lo_q <= opdata_q;
            endcase
          end
          // Only ones may turn to zeros here; boot bits frozen in mode 3
          OP_LOCK: lock_q <= lock_q & (lock_mode3 ? (opdata_q | LOCK_BOOT_MASK) : opdata_q);
          OP_ERASE: lock_q <= LOCK_RST;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (pl_rise && cmd_q == CMD_WR_FLASH) fpage_q[pidx] <= {dat_hi_q, dat_lo_q};
    if (pl_rise && cmd_q == CMD_WR_EE) epage_q[pidx] <= dat_lo_q;
    if (commit && op_q == OP_ERASE) begin
      for (int i = 0; i < 2**FLASH_AW; i++) flash_q[i] <= {ERASED_BYTE, ERASED_BYTE};
      for (int i = 0; i < 2**EE_AW; i++) ee_q[i] <= ERASED_BYTE;
    end
    for (int p = 0; p < 2**PAGE_AW; p++) begin
      if (commit && op_q == OP_FLASH && fvalid_q[p])
        flash_q[{faddr[FLASH_AW-1:PAGE_AW], PAGE_AW'(p)}] <= fpage_q[p];
      if (commit && op_q == OP_EE && evalid_q[p])
        ee_q[{eaddr[EE_AW-1:PAGE_AW], PAGE_AW'(p)}] <= epage_q[p];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    case (cmd_q)
      CMD_RD_FLASH: rd_d = PP.low_byte_select ? flash_q[faddr][15:8] : flash_q[faddr][7:0];
      CMD_RD_EE: rd_d = ee_q[eaddr];
      CMD_RD_FUSE: begin
        case ({PP.upper_byte_select, PP.low_byte_select})
          2'b00: rd_d = fuse_lo_q;
          2'b11: rd_d = fuse_hi_q;
          2'b10: rd_d = fuse_ex_q;
          default: rd_d = lock_q;
        endcase
      end
      CMD_RD_SIG: begin
        if (PP.low_byte_select) rd_d = (addr_lo_q == CAL_ADDR) ? CAL_BYTE : 8'h00;
        else if (addr_lo_q == 8'h00) rd_d = SIG0;
        else if (addr_lo_q == 8'h01) rd_d = SIG1;
        else if (addr_lo_q == SIG_MAX_ADDR) rd_d = SIG2;
        else rd_d = 8'h00;
      end
      default: rd_d = 8'h00;
    endcase
  end

  // Output register: one cycle of latency after output enable falls
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dout_q <= 8'h00;
      dout_oe_q <= 8'h00;
    end else begin
      dout_q <= rd_d;
      dout_oe_q <= {8{~PP.out_en_n & PP.prog_mode}};
    end
  end

  assign PP.data_dev = dout_q;
  assign PP.data_dev_oe = dout_oe_q;
  assign PP.done_flag = done_q;
endmodule
`default_nettype wire

//--- hdl/pport_prog.sv
`timescale 1ns/1ps
`default_nettype none
module pport_prog
  import pport_pkg::*;
#(
  parameter int HOLD_CYC = ENTRY_HOLD_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // User request: one step per pulse
  input wire logic REQ_I,
  input wire logic [2:0] KIND_I,
  input wire logic [1:0] ACT_I,
  input wire logic [1:0] SEL_I,
  input wire logic [7:0] DATA_I,
  // User answer
  output logic BUSY_O,
  output logic ACK_O,
  output logic [7:0] RDATA_O,
  // Programming port
  pport_if.prog PP
);
  typedef enum logic [2:0] {
    P_ENTRY = 3'b000,
    P_IDLE = 3'b001,
    P_HI = 3'b010,
    P_LO = 3'b011,
    P_WAITLO = 3'b100,
    P_WAITHI = 3'b101
  } pstate_t;
  // ---------------------------------------------------------------
  // Step kinds: 0 load, 1 page latch, 2 program, 3 read
  // ---------------------------------------------------------------
  pstate_t st_q, st_d;
  logic [$clog2(HOLD_CYC+1)-1:0] cnt_q, cnt_d;
  logic [2:0] kind_q, kind_d;
  logic [1:0] act_q, act_d, sel_q, sel_d;
  logic [7:0] dat_q, dat_d, rdat_q, rdat_d;
  logic ack_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    kind_d = kind_q;
    act_d = act_q;
    sel_d = sel_q;
    dat_d = dat_q;
    rdat_d = rdat_q;
    ack_d = 1'b0;
    case (st_q)
      P_ENTRY: begin
        // Entry pins stay zero until the hold time has passed
        if (cnt_q == '0) st_d = P_IDLE;
        else cnt_d = cnt_q - 1'b1;
      end
      P_IDLE: begin
        if (REQ_I) begin
          kind_d = KIND_I;
          act_d = ACT_I;
          sel_d = SEL_I;
          dat_d = DATA_I;
          cnt_d = ($clog2(HOLD_CYC+1))'(STROBE_CYC);
          st_d = P_HI;
        end
      end
      P_HI: begin
        if (cnt_q == '0) begin
          cnt_d = ($clog2(HOLD_CYC+1))'(STROBE_CYC);
          st_d = P_LO;
        end else cnt_d = cnt_q - 1'b1;
      end
      P_LO: begin
        if (cnt_q == '0) begin
          if (kind_q == 3'd3) rdat_d = PP.data_bus;
          st_d = (kind_q == 3'd2) ? P_WAITLO : P_IDLE;
          ack_d = (kind_q != 3'd2);
          cnt_d = ($clog2(HOLD_CYC+1))'(STROBE_CYC);
        end else cnt_d = cnt_q - 1'b1;
      end
      P_WAITLO: begin
        if (!PP.done_flag) st_d = P_WAITHI;
        else if (cnt_q == '0) st_d = P_WAITHI;
        else cnt_d = cnt_q - 1'b1;
      end
      P_WAITHI: begin
        if (PP.done_flag) begin
          st_d = P_IDLE;
          ack_d = 1'b1;
        end
      end
      default: st_d = P_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_q <= P_ENTRY;
      cnt_q <= ($clog2(HOLD_CYC+1))'(HOLD_CYC);
      kind_q <= 3'd0;
      act_q <= ACT_IDLE;
      sel_q <= 2'h0;
      dat_q <= 8'h00;
      rdat_q <= 8'h00;
      ACK_O <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      kind_q <= kind_d;
      act_q <= act_d;
      sel_q <= sel_d;
      dat_q <= dat_d;
      rdat_q <= rdat_d;
      ACK_O <= ack_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive, all from flip-flops
  // ---------------------------------------------------------------
  logic ls_q, pl_q, wr_n_q, oe_n_q, pm_q, bus_oe_q, busy_q;
  logic [1:0] act_pin_q, sel_pin_q;
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ls_q <= 1'b0;
      pl_q <= 1'b0;
      wr_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      pm_q <= 1'b0;
      bus_oe_q <= 1'b1;
      busy_q <= 1'b1;
      act_pin_q <= 2'h0;
      sel_pin_q <= 2'h0;
    end else begin
      pm_q <= (st_d != P_ENTRY);
      busy_q <= (st_d != P_IDLE);
      act_pin_q <= (st_d == P_ENTRY) ? 2'h0 : act_d;
      // Selects return to zero when idle, after fuse high or extended writes
      sel_pin_q <= (st_d == P_IDLE || st_d == P_ENTRY) ? 2'h0 : sel_d;
      ls_q <= (st_d == P_LO) && (kind_d == 3'd0);
      pl_q <= (st_d == P_LO) && (kind_d == 3'd1);
      wr_n_q <= !((st_d == P_LO) && (kind_d == 3'd2));
      oe_n_q <= !((st_d == P_HI || st_d == P_LO) && (kind_d == 3'd3));
      // Release the bus with output enable, take it back only a cycle after
      // output enable rises, since the device lets go of it one cycle late
      bus_oe_q <= oe_n_q &&
                  ((st_d == P_ENTRY) || !(kind_d == 3'd3 && st_d != P_IDLE));
    end
  end

  assign PP.load_strobe = ls_q;
  assign PP.page_latch_strobe = pl_q;
  assign PP.write_n = wr_n_q;
  assign PP.out_en_n = oe_n_q;
  assign PP.prog_mode = pm_q;
  assign PP.action_select_hi = act_pin_q[1];
  assign PP.action_select_lo = act_pin_q[0];
  assign PP.low_byte_select = sel_pin_q[0];
  assign PP.upper_byte_select = sel_pin_q[1];
  assign PP.data_prog = dat_q;
  assign PP.data_prog_oe = {8{bus_oe_q}};
  assign BUSY_O = busy_q;
  assign RDATA_O = rdat_q;
endmodule
`default_nettype wire

//--- verification/pport_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pport_chk
  import pport_pkg::*;
#(
  parameter int HOLD_CYC = 4
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Port pins
  input wire logic action_select_hi,
  input wire logic action_select_lo,
  input wire logic low_byte_select,
  input wire logic page_latch_strobe,
  input wire logic load_strobe,
  input wire logic write_n,
  input wire logic out_en_n,
  input wire logic done_flag,
  input wire logic prog_mode,
  input wire logic [7:0] data_prog_oe,
  input wire logic [7:0] data_dev_oe,
  input wire logic [7:0] data_bus
);
  localparam int BUSY_LEN = PROG_BUSY_CYC + 1;
  int ent_q;
  int ent_d;
  int low_q;
  int low_d;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // --------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------
  // Quiet entry cycles and busy cycles; plain counts, the asserts pick the figure
  always_comb begin
    ent_d = ent_q + 1;
    if (prog_mode || action_select_hi || action_select_lo || low_byte_select || page_latch_strobe) begin
      ent_d = 0;
    end
    low_d = done_flag ? 0 : low_q + 1;
  end
  // Register the counters
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ent_q <= 0;
      low_q <= 0;
    end else begin
      ent_q <= ent_d;
      low_q <= low_d;
    end
  end
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  AST_ENTRY_HOLD: assert property ($rose(prog_mode) |-> ent_q >= HOLD_CYC)
    else $error("entry code not held long enough");
  AST_IDLE_BEFORE_ENTRY: assert property (!prog_mode |-> done_flag && data_dev_oe == 8'h00)
    else $error("device active before entry");
  AST_DONE_CAUSE: assert property ($fell(done_flag) |-> $past(write_n, 2) && !$past(write_n))
    else $error("done fell without a program strobe");
  AST_DONE_LEN: assert property ($rose(done_flag) |-> low_q == BUSY_LEN)
    else $error("busy time wrong");
  AST_WRN_READY: assert property ($fell(write_n) |-> done_flag)
    else $error("program strobe while busy");
  AST_STROBE_HOLD: assert property ($rose(load_strobe) |-> $stable({action_select_hi, action_select_lo, data_bus})[*3])
    else $error("action or data moved under load strobe");
  AST_STROBE_LEN: assert property ($rose(load_strobe) |-> load_strobe[*3] ##1 !load_strobe)
    else $error("load strobe width wrong");
  AST_OE_ON: assert property ($fell(out_en_n) |-> ##[1:2] (data_dev_oe == 8'hff))
    else $error("device did not drive the bus");
  AST_OE_OFF: assert property (out_en_n && $past(out_en_n) |-> data_dev_oe == 8'h00)
    else $error("device drove the bus without output enable");
  AST_NO_CLASH: assert property ((data_dev_oe & data_prog_oe) == 8'h00)
    else $error("both ends drive the bus");
  AST_LATCH_QUIET: assert property ($rose(page_latch_strobe) |-> out_en_n && write_n && !load_strobe)
    else $error("page latch overlaps another strobe");
  // Main scenarios reached
  cover property ($fell(done_flag));
  cover property ($rose(prog_mode));
  cover property ($rose(data_dev_oe[0]));
endmodule
`default_nettype wire

//--- verification/parallel_memory_programming_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_memory_programming_port_bench;
  import pport_pkg::*;
  localparam logic [7:0] SIG_A = 8'h5c; // Arbitrary value
  localparam logic [7:0] SIG_B = 8'ha3; // Arbitrary value
  localparam logic [7:0] SIG_C = 8'h69; // Arbitrary value
  localparam logic [7:0] CAL = 8'h4e; // Arbitrary value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [1:0] act = 2'h0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic busy;
  logic ack;
  logic [7:0] rdata;
  logic [7:0] junk;
  int bad_count = 0;
  int tests_run = 0;
  // --------------------------------------------------------------
  // Both ends joined across the interface
  // --------------------------------------------------------------
  pport_if pif ();
  pport_dev #(.SIG0(SIG_A), .SIG1(SIG_B), .SIG2(SIG_C), .CAL_BYTE(CAL)) i_pport_dev (
    .CORE_CLK_I(clk),
    .RSTN_I(rstn),
    .PP(pif.dev)
  );
  // Short entry hold keeps the run brief
  pport_prog #(.HOLD_CYC(4)) i_pport_prog (
    .CORE_CLK_I(clk),
    .RSTN_I(rstn),
    .REQ_I(req),
    .KIND_I(kind),
    .ACT_I(act),
    .SEL_I(sel),
    .DATA_I(wdata),
    .BUSY_O(busy),
    .ACK_O(ack),
    .RDATA_O(rdata),
    .PP(pif.prog)
  );
  pport_chk #(.HOLD_CYC(4)) i_pport_chk (
    .CORE_CLK_I(clk),
    .RSTN_I(rstn),
    .action_select_hi(pif.action_select_hi),
    .action_select_lo(pif.action_select_lo),
    .low_byte_select(pif.low_byte_select),
    .page_latch_strobe(pif.page_latch_strobe),
    .load_strobe(pif.load_strobe),
    .write_n(pif.write_n),
    .out_en_n(pif.out_en_n),
    .done_flag(pif.done_flag),
    .prog_mode(pif.prog_mode),
    .data_prog_oe(pif.data_prog_oe),
    .data_dev_oe(pif.data_dev_oe),
    .data_bus(pif.data_bus)
  );
  // Free running clock
  always #5 clk = ~clk;
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One user step; request pulsed for one cycle, then a wait for the answer, which is bounded
  task automatic step(input logic [2:0] k, input logic [1:0] a, input logic [1:0] s,
                      input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 500);
    req <= 1'b1;
    kind <= k;
    act <= a;
    sel <= s;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 500);
    check({7'h00, ack}, 8'h01);
    check({7'h00, busy}, 8'h00);
    r = rdata;
  endtask
  task automatic ld(input logic [1:0] a, input logic [1:0] s, input logic [7:0] d);
    step(3'h0, a, s, d, junk);
  endtask
  task automatic cmd(input logic [7:0] c);
    ld(ACT_CMD, 2'h0, c);
  endtask
  task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
    ld(ACT_ADDR, 2'h1, hi);
    ld(ACT_ADDR, 2'h0, lo);
  endtask
  task automatic latch(input logic [1:0] s);
    step(3'h1, 2'h0, s, 8'h00, junk);
  endtask
  task automatic prog(input logic [1:0] s);
    step(3'h2, 2'h0, s, 8'h00, junk);
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] v);
    step(3'h3, 2'h0, s, 8'h00, v);
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_fuse();
    logic [7:0] v;
    cmd(CMD_WR_FUSE);
    ld(ACT_DATA, 2'h0, 8'ha5);
    prog(2'h0);
    ld(ACT_DATA, 2'h0, 8'h5a);
    prog(2'h1);
    ld(ACT_DATA, 2'h0, 8'hc3);
    prog(2'h2);
    cmd(CMD_RD_FUSE);
    rd(2'h0, v);
    check(v, 8'ha5);
    rd(2'h3, v);
    check(v, 8'h5a);
    rd(2'h2, v);
    check(v, 8'hc3);
    rd(2'h1, v);
    check(v, LOCK_RST);
    $display("test fuse done");
  endtask
  // Two bytes into one page; a byte latched before the nop must not commit
  task automatic test_ee();
    logic [7:0] v;
    cmd(CMD_WR_EE);
    addr(8'h00, 8'h04);
    ld(ACT_DATA, 2'h0, 8'h3c);
    latch(2'h0);
    ld(ACT_ADDR, 2'h0, 8'h05);
    ld(ACT_DATA, 2'h0, 8'hc3);
    latch(2'h0);
    prog(2'h0);
    ld(ACT_DATA, 2'h0, 8'h00);
    latch(2'h0);
    cmd(CMD_NOP);
    cmd(CMD_WR_EE);
    prog(2'h0);
    cmd(CMD_RD_EE);
    addr(8'h00, 8'h04);
    rd(2'h0, v);
    check(v, 8'h3c);
    ld(ACT_ADDR, 2'h0, 8'h05);
    rd(2'h0, v);
    check(v, 8'hc3);
    $display("test eeprom done");
  endtask
  task automatic test_flash();
    logic [7:0] v;
    cmd(CMD_WR_FLASH);
    ld(ACT_ADDR, 2'h0, 8'h01);
    ld(ACT_DATA, 2'h0, 8'h34);
    ld(ACT_DATA, 2'h1, 8'h12);
    latch(2'h1);
    ld(ACT_ADDR, 2'h1, 8'h00);
    prog(2'h0);
    cmd(CMD_NOP);
    cmd(CMD_RD_FLASH);
    addr(8'h00, 8'h01);
    rd(2'h0, v);
    check(v, 8'h34);
    rd(2'h1, v);
    check(v, 8'h12);
    $display("test flash done");
  endtask
  // An idle action in between must not disturb the loaded command
  task automatic test_sig();
    logic [7:0] v;
    logic [7:0] sigs [3];
    sigs = '{SIG_A, SIG_B, SIG_C};
    cmd(CMD_RD_SIG);
    ld(ACT_IDLE, 2'h0, CMD_NOP);
    for (int i = 0; i < 3; i++) begin
      ld(ACT_ADDR, 2'h0, i[7:0]);
      rd(2'h0, v);
      check(v, sigs[i]);
    end
    ld(ACT_ADDR, 2'h0, CAL_ADDR);
    rd(2'h1, v);
    check(v, CAL);
    $display("test signature done");
  endtask
  // Lock mode 3 then a boot lock attempt, then erase restores locks and arrays
  task automatic test_lock();
    logic [7:0] v;
    cmd(CMD_WR_LOCK);
    ld(ACT_DATA, 2'h0, 8'hfc);
    prog(2'h0);
    ld(ACT_DATA, 2'h0, 8'hc3);
    prog(2'h0);
    cmd(CMD_RD_FUSE);
    rd(2'h1, v);
    check(v, 8'hfc);
    cmd(CMD_ERASE);
    prog(2'h0);
    cmd(CMD_RD_FUSE);
    rd(2'h1, v);
    check(v, LOCK_RST);
    rd(2'h0, v);
    check(v, 8'ha5);
    cmd(CMD_RD_EE);
    addr(8'h00, 8'h04);
    rd(2'h0, v);
    check(v, ERASED_BYTE);
    cmd(CMD_RD_FLASH);
    addr(8'h00, 8'h01);
    rd(2'h1, v);
    check(v, ERASED_BYTE);
    $display("test lock done");
  endtask
  // --------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence after a three cycle reset
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    test_fuse();
    test_ee();
    test_flash();
    test_sig();
    test_lock();
    stop_test();
  end
  // Watchdog, well above the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
